/* inc/irqs_pkg.sv */
// Purpose: Shared constants and carriers for the event status mode block
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes:   Register indices are word indices; byte address is index times four
package irqs_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned REG_W  = 8;
    localparam int unsigned VEC_W  = 3 * REG_W;

    // Word indices of the registers
    localparam logic [7:0] IDX_MODE_A = 8'h1F;
    localparam logic [7:0] IDX_MODE_B = 8'h20;
    localparam logic [7:0] IDX_MODE_C = 8'h21;
    localparam logic [7:0] IDX_STAT_A = 8'h23;
    localparam logic [7:0] IDX_STAT_B = 8'h24;
    localparam logic [7:0] IDX_STAT_C = 8'h25;

    // Writable bits of each mode register; all others are reserved
    localparam logic [7:0] MASK_A = 8'h1E;
    localparam logic [7:0] MASK_B = 8'h05;
    localparam logic [7:0] MASK_C = 8'hAF;

    localparam logic [7:0]  RST_MODE   = 8'h00;
    localparam logic [31:0] RST_RDATA  = 32'h0000_0000;
    localparam logic        RST_IRQ_N  = 1'b1;

    // Bit positions inside the mode and status registers
    localparam int unsigned POS_CONV_PLL_LOCK = 4;
    localparam int unsigned POS_LINK_PLL_LOSS = 3;
    localparam int unsigned POS_LINK_PLL_LOCK = 2;
    localparam int unsigned POS_LANE_BUF_ERR  = 1;
    localparam int unsigned POS_CH1_SEQ_ERR   = 2;
    localparam int unsigned POS_CH0_SEQ_ERR   = 0;
    localparam int unsigned POS_CH0_PWR_DET   = 7;
    localparam int unsigned POS_CH0_BLANK     = 5;
    localparam int unsigned POS_CH0_ALIGN_LCK = 3;
    localparam int unsigned POS_CH0_ALIGN_ROT = 2;
    localparam int unsigned POS_CH0_ALIGN_WIN = 1;
    localparam int unsigned POS_CH0_ALIGN_TRP = 0;

    typedef struct packed {
        logic convPllLocked;
        logic linkPllLost;
        logic linkPllLocked;
        logic laneBufError;
        logic ch1SeqCheckError;
        logic ch0SeqCheckError;
        logic ch0PowerDetError;
        logic ch0BlankDone;
        logic ch0AlignLocked;
        logic ch0AlignRotated;
        logic ch0AlignOutsideWindow;
        logic ch0AlignTripped;
    } irqs_src_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } irqs_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } irqs_apb_rsp_t;

endpackage

/* rtl/irqs_mode_reg.sv */
// Purpose: One 8-bit mode register with a write mask
// Assumes: Synchronous active-low reset
// Notes:   Bits outside WMASK keep their reset value of zero
`timescale 1ns/1ps
module irqs_mode_reg #(
    parameter logic [7:0] WMASK = 8'h00
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       wrEn,
    input  wire logic [7:0] wdata,
    output logic      [7:0] value
);
    import irqs_pkg::*;

    typedef struct packed {
        logic [7:0] mode;
    } irqs_mode_state_t;

    irqs_mode_state_t state_reg;
    irqs_mode_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (wrEn) begin
            state_next.mode = wdata & WMASK; // [RQ17]
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_reg.mode <= RST_MODE; // [RQ5] [RQ6]
        end else begin
            state_reg <= state_next;
        end
    end

    assign value = state_reg.mode;
endmodule

/* rtl/irqs_status_cell.sv */
// Purpose: Live or edge-latched status for a vector of event sources
// Assumes: Sources synchronous to clk
// Notes:   Latches drop when their mode bit is cleared, so live bits never hold a request
`timescale 1ns/1ps
module irqs_status_cell #(
    parameter int unsigned W = 24
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] mode,
    input  wire logic [W-1:0] src,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] stat,
    output logic      [W-1:0] pend
);
    import irqs_pkg::*;

    typedef struct packed {
        logic [W-1:0] srcPrev;
        logic [W-1:0] lat;
    } irqs_cell_state_t;

    irqs_cell_state_t state_reg;
    irqs_cell_state_t state_next;
    logic [W-1:0]     rise;

    always_comb begin
        state_next         = state_reg;
        state_next.srcPrev = src;
        rise               = src & ~state_reg.srcPrev; // [RQ15]
        // A rise in the clearing cycle wins over the clear
        state_next.lat     = mode & ((state_reg.lat & ~clr) | rise); // [RQ14] [RQ15]
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign stat = (mode & state_reg.lat) | (~mode & src); // [RQ13]
    assign pend = state_reg.lat;
endmodule

/* rtl/irqs_status_mode_top.sv */
// Purpose: Status mode selection and active-low interrupt request over APB
// Assumes: Event inputs synchronous to clk; APB master per AMBA APB
// Notes:   Each access takes one wait state; unmapped or unaligned gives pslverr
`timescale 1ns/1ps

// Behaviour
// [RQ1] Converter PLL lock bit 4 latches, asserts request
// [RQ2] Link PLL loss bit 3 latches, asserts request
// [RQ3] Link PLL lock bit 2 latches, asserts request
// [RQ4] Lane buffer error bit 1 latches, asserts request
// [RQ5] Second register bit 2 selects ch1 sequence error
// [RQ6] Second register bit 0 ch0 sequence; reset zero
// [RQ7] Third register bit 7 ch0 power detect
// [RQ8] Third register bit 5 ch0 blank done
// [RQ9] Third register bit 3 ch0 align locked
// [RQ10] Third register bit 2 ch0 align rotated
// [RQ11] Third register bit 1 ch0 outside window
// [RQ12] Third register bit 0 ch0 align tripped
// [RQ13] Mode zero shows live level, no request
// [RQ14] Latched bit cleared by writing one
// [RQ15] Latch on rising edge, not level
// [RQ16] Request low while any latched bit set
// [RQ17] Reserved bits ignore writes, read zero
module irqs_status_mode_top #(
    parameter int unsigned PADDR_W = irqs_pkg::ADDR_W
) (
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire irqs_pkg::irqs_apb_req_t apbReq,
    input  wire irqs_pkg::irqs_src_t     srcIn,
    output irqs_pkg::irqs_apb_rsp_t      apbRsp,
    output logic                         irqReqN
);
    import irqs_pkg::*;

    if (PADDR_W != ADDR_W || PADDR_W < 10) begin : g_chk
        $error("irqs_status_mode_top: PADDR_W must equal ADDR_W and be at least 10");
    end

    typedef struct packed {
        irqs_apb_rsp_t rsp;
        logic          irqN;
    } irqs_top_state_t;

    irqs_top_state_t state_reg;
    irqs_top_state_t state_next;

    logic [7:0]       modeA;
    logic [7:0]       modeB;
    logic [7:0]       modeC;
    logic [VEC_W-1:0] modeVec;
    logic [VEC_W-1:0] srcVec;
    logic [VEC_W-1:0] clrVec;
    logic [VEC_W-1:0] statVec;
    logic [VEC_W-1:0] pendVec;
    logic             access;
    logic             wrFire;
    logic [7:0]       idx;
    logic             aligned;

    // Places each source at the bit of its mode register
    function automatic logic [VEC_W-1:0] place(input irqs_src_t s);
        logic [VEC_W-1:0] v;
        v = '0;
        v[POS_CONV_PLL_LOCK]           = s.convPllLocked;         // [RQ1]
        v[POS_LINK_PLL_LOSS]           = s.linkPllLost;           // [RQ2]
        v[POS_LINK_PLL_LOCK]           = s.linkPllLocked;         // [RQ3]
        v[POS_LANE_BUF_ERR]            = s.laneBufError;          // [RQ4]
        v[REG_W + POS_CH1_SEQ_ERR]     = s.ch1SeqCheckError;      // [RQ5]
        v[REG_W + POS_CH0_SEQ_ERR]     = s.ch0SeqCheckError;      // [RQ6]
        v[2*REG_W + POS_CH0_PWR_DET]   = s.ch0PowerDetError;      // [RQ7]
        v[2*REG_W + POS_CH0_BLANK]     = s.ch0BlankDone;          // [RQ8]
        v[2*REG_W + POS_CH0_ALIGN_LCK] = s.ch0AlignLocked;        // [RQ9]
        v[2*REG_W + POS_CH0_ALIGN_ROT] = s.ch0AlignRotated;       // [RQ10]
        v[2*REG_W + POS_CH0_ALIGN_WIN] = s.ch0AlignOutsideWindow; // [RQ11]
        v[2*REG_W + POS_CH0_ALIGN_TRP] = s.ch0AlignTripped;       // [RQ12]
        return v;
    endfunction

    function automatic logic isIdx(input logic [7:0] a, input logic [7:0] b, input logic ok);
        return ok && (a == b);
    endfunction

    assign idx     = apbReq.paddr[9:2];
    assign aligned = (apbReq.paddr[1:0] == 2'b00) && (apbReq.paddr[PADDR_W-1:10] == '0);
    assign access  = apbReq.psel & apbReq.penable;
    // Writes land only on the edge that completes the transfer
    assign wrFire  = access & apbReq.pwrite & state_reg.rsp.pready;

    irqs_mode_reg #(.WMASK(MASK_A)) u_modeA (
        .clk   (clk),
        .rstn  (rstn),
        .wrEn  (wrFire & isIdx(idx, IDX_MODE_A, aligned)),
        .wdata (apbReq.pwdata[7:0]),
        .value (modeA)
    );

    irqs_mode_reg #(.WMASK(MASK_B)) u_modeB (
        .clk   (clk),
        .rstn  (rstn),
        .wrEn  (wrFire & isIdx(idx, IDX_MODE_B, aligned)),
        .wdata (apbReq.pwdata[7:0]),
        .value (modeB)
    );

    irqs_mode_reg #(.WMASK(MASK_C)) u_modeC (
        .clk   (clk),
        .rstn  (rstn),
        .wrEn  (wrFire & isIdx(idx, IDX_MODE_C, aligned)),
        .wdata (apbReq.pwdata[7:0]),
        .value (modeC)
    );

    assign modeVec = {modeC, modeB, modeA};
    assign srcVec  = place(srcIn);

    // Write-one-to-clear on the status words; live bits have no latch to clear
    always_comb begin
        clrVec = '0;
        if (wrFire && isIdx(idx, IDX_STAT_A, aligned)) begin
            clrVec[REG_W-1:0] = apbReq.pwdata[7:0]; // [RQ14]
        end
        if (wrFire && isIdx(idx, IDX_STAT_B, aligned)) begin
            clrVec[2*REG_W-1:REG_W] = apbReq.pwdata[7:0]; // [RQ14]
        end
        if (wrFire && isIdx(idx, IDX_STAT_C, aligned)) begin
            clrVec[3*REG_W-1:2*REG_W] = apbReq.pwdata[7:0]; // [RQ14]
        end
    end

    irqs_status_cell #(.W(VEC_W)) u_cell (
        .clk  (clk),
        .rstn (rstn),
        .mode (modeVec),
        .src  (srcVec),
        .clr  (clrVec),
        .stat (statVec),
        .pend (pendVec)
    );

    always_comb begin
        state_next             = state_reg;
        state_next.rsp.pready  = access & ~state_reg.rsp.pready;
        state_next.irqN        = ~|pendVec; // [RQ16]
        if (access && !state_reg.rsp.pready) begin
            state_next.rsp.pslverr = 1'b0;
            state_next.rsp.prdata  = RST_RDATA;
            if (!aligned) begin
                state_next.rsp.pslverr = 1'b1;
            end else begin
                case (idx)
                    IDX_MODE_A: state_next.rsp.prdata[7:0] = modeA; // [RQ17]
                    IDX_MODE_B: state_next.rsp.prdata[7:0] = modeB;
                    IDX_MODE_C: state_next.rsp.prdata[7:0] = modeC;
                    IDX_STAT_A: state_next.rsp.prdata[7:0] = statVec[REG_W-1:0];
                    IDX_STAT_B: state_next.rsp.prdata[7:0] = statVec[2*REG_W-1:REG_W];
                    IDX_STAT_C: state_next.rsp.prdata[7:0] = statVec[3*REG_W-1:2*REG_W];
                    default:    state_next.rsp.pslverr     = 1'b1;
                endcase
            end
        end else if (!access) begin
            state_next.rsp.pslverr = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_reg.rsp.pready  <= 1'b0;
            state_reg.rsp.prdata  <= RST_RDATA;
            state_reg.rsp.pslverr <= 1'b0;
            state_reg.irqN        <= RST_IRQ_N;
        end else begin
            state_reg <= state_next;
        end
    end

    assign apbRsp  = state_reg.rsp;
    assign irqReqN = state_reg.irqN;
endmodule

/* testbench/irqs_status_mode_sva.sv */
// Purpose: Port-level checks of the status mode block
// Assumes: Single clock domain, synchronous active-low reset
// Notes:   Latency windows are kept loose where the bus contract allows
`timescale 1ns/1ps
module irqs_status_mode_sva (
    input wire logic                    clk,
    input wire logic                    rstn,
    input wire irqs_pkg::irqs_apb_req_t apbReq,
    input wire irqs_pkg::irqs_src_t     srcIn,
    input wire irqs_pkg::irqs_apb_rsp_t apbRsp,
    input wire logic                    irqReqN
);
    import irqs_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    irqs_src_t  prevSrc;
    logic [3:0] riseHist;
    logic [3:0] wrHist;
    logic       wrDone;
    assign wrDone = apbRsp.pready && apbReq.psel && apbReq.penable && apbReq.pwrite;
    always_ff @(posedge clk) begin
        prevSrc  <= srcIn;
        riseHist <= {riseHist[2:0], |(srcIn & ~prevSrc)};
        wrHist   <= {wrHist[2:0], wrDone};
    end

    sequence s_wait;
        apbReq.psel && apbReq.penable && !apbRsp.pready;
    endsequence
    sequence s_done;
        apbRsp.pready;
    endsequence

    AST_READY_ONE_WAIT: assert property (s_wait |=> s_done)
        else $error("pready late");
    AST_READY_PULSE: assert property (s_done |=> !apbRsp.pready)
        else $error("pready longer than one cycle");
    AST_READY_CAUSE: assert property (s_done |-> $past(apbReq.psel && apbReq.penable))
        else $error("pready without access");
    AST_RDATA_UPPER: assert property (s_done |-> apbRsp.prdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    AST_UNMAPPED_ERR: assert property ((s_done and (apbReq.paddr == 12'h088)) |->
        apbRsp.pslverr && apbRsp.prdata == 32'h00000000)
        else $error("unmapped access not refused");
    AST_IRQ_FALL_EDGE: assert property ($fell(irqReqN) |-> riseHist != 4'h0)
        else $error("request without source rise");
    AST_IRQ_RISE_WRITE: assert property ($rose(irqReqN) |-> wrHist != 4'h0)
        else $error("request released without write");
    AST_IRQ_NO_ERR_WR: assert property ((s_done and (apbReq.paddr == 12'h07C)) |->
        !apbRsp.pslverr)
        else $error("mode register refused");
endmodule
bind irqs_status_mode_top irqs_status_mode_sva irqs_status_mode_sva_inst (
    .clk(clk), .rstn(rstn), .apbReq(apbReq), .srcIn(srcIn), .apbRsp(apbRsp),
    .irqReqN(irqReqN));

/* testbench/testbench.sv */
// Purpose: Self-checking bench for the status mode block
// Assumes: APB master holds each request until pready
// Notes:   Sources rise together except ch0AlignTripped rising alone late in t_latch; distinct bit positions still separate them
`timescale 1ns/1ps
module testbench;
    import irqs_pkg::*;
    logic          clk;
    logic          rstn;
    irqs_apb_req_t apbReq;
    irqs_src_t     srcIn;
    irqs_apb_rsp_t apbRsp;
    logic          irqReqN;
    int            mismatches;
    int            comparisons;
    int            cycles;
    logic [31:0]   rd;
    logic          err;
    logic [7:0]    modeIdx [3] = '{8'h1F, 8'h20, 8'h21};
    logic [7:0]    statIdx [3] = '{8'h23, 8'h24, 8'h25};
    logic [7:0]    usable  [3] = '{8'h1E, 8'h05, 8'hAF};

    irqs_status_mode_top irqs_status_mode_top_inst (
        .clk(clk), .rstn(rstn), .apbReq(apbReq), .srcIn(srcIn), .apbRsp(apbRsp),
        .irqReqN(irqReqN));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {2'b00, idx, 2'b00}, pwdata: d};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        do @(posedge clk); while (apbRsp.pready !== 1'b1);
        rd  = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq.psel    <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    task automatic t_modes();
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, modeIdx[i], 32'h0);
            chk(rd, 32'h0);
            apb(1'b1, modeIdx[i], 32'hFFFFFFFF);
            apb(1'b0, modeIdx[i], 32'h0);
            chk(rd, {24'h0, usable[i]});
        end
        apb(1'b1, 8'h22, 32'hFF);
        chk({31'h0, err}, 32'h1);
    endtask

    task automatic t_live();
        for (int i = 0; i < 3; i++) apb(1'b1, modeIdx[i], 32'h0);
        srcIn <= '1;
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, statIdx[i], 32'hFF);
            apb(1'b0, statIdx[i], 32'h0);
            chk(rd, {24'h0, usable[i]});
        end
        chk({31'h0, irqReqN}, 32'h1);
        srcIn <= '0;
        apb(1'b0, statIdx[2], 32'h0);
        chk(rd, 32'h0);
    endtask

    task automatic t_latch();
        for (int i = 0; i < 3; i++) apb(1'b1, modeIdx[i], 32'hFF);
        srcIn <= '1;
        repeat (4) @(posedge clk);
        chk({31'h0, irqReqN}, 32'h0);
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, statIdx[i], 32'h0);
            chk(rd, {24'h0, usable[i]});
        end
        apb(1'b1, statIdx[0], 32'hFF);
        apb(1'b0, statIdx[0], 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, irqReqN}, 32'h0);
        apb(1'b1, statIdx[1], 32'hFF);
        apb(1'b1, statIdx[2], 32'hFF);
        repeat (3) @(posedge clk);
        chk({31'h0, irqReqN}, 32'h1);
        srcIn <= '0;
        repeat (2) @(posedge clk);
        srcIn <= 12'h001;
        apb(1'b0, statIdx[2], 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, modeIdx[2], 32'h0);
        repeat (3) @(posedge clk);
        chk({31'h0, irqReqN}, 32'h1);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            print_verdict();
        end
    end

    initial begin
        rstn   = 1'b0;
        apbReq = '0;
        srcIn  = '0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        chk({31'h0, irqReqN}, 32'h1);
        t_modes();
        t_live();
        t_latch();
        print_verdict();
    end
endmodule
